// [hsd_pkg.sv]
// hsd_pkg: shared constants for the headset detect and record gain registers
package hsd_pkg;

  // ----------------------------------------
  // register access widths
  // ----------------------------------------
  localparam int ADDR_W = 8;                  // register address width
  localparam int DATA_W = 8;                  // register data width

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_DET_CTRL = 8'h0D; // headset_detect_ctrl
  localparam logic [7:0] OFS_STAT_CFG = 8'h0E; // headset_status_driver_cfg
  localparam logic [7:0] OFS_GAIN_L   = 8'h0F; // left_record_gain
  localparam logic [7:0] OFS_GAIN_R   = 8'h10; // right_record_gain

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int DET_EN_BIT   = 7;            // detection enable
  localparam int TYPE_LSB     = 5;            // headset type, 2 bits
  localparam int JDB_LSB      = 2;            // jack debounce code, 3 bits
  localparam int BDB_LSB      = 0;            // button debounce code, 2 bits
  localparam int COUPLE_BIT   = 7;            // ac-coupled outputs
  localparam int FULLDIFF_BIT = 6;            // fully-differential outputs
  localparam int BTN_FLAG_BIT = 5;            // sticky button flag
  localparam int HS_FLAG_BIT  = 4;            // headset present
  localparam int PSEUDO_BIT   = 3;            // pseudo-differential outputs
  localparam int MUTE_BIT     = 7;            // record stage mute
  localparam int GAIN_LSB     = 0;            // record gain, 7 bits

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_DET_CTRL = 8'h00; // detection off, fastest debounce
  localparam logic [7:0] RST_STAT_CFG = 8'h00; // capless, no differential mode
  localparam logic [7:0] RST_GAIN     = 8'h80; // muted, 0.0 dB

  // ----------------------------------------
  // codes and timing
  // ----------------------------------------
  localparam logic [6:0] GAIN_MAX_CODE = 7'h77; // 59.5 dB ceiling
  localparam int CLK_PERIOD_NS = 10;            // 100 MHz system clock
  localparam int TICK_BASE_MS  = 1;             // finest sample tick
  localparam int NS_PER_MS     = 1000000;       // unit conversion
  localparam int MS_CYCLES_DEF = TICK_BASE_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int DB_SAMPLES    = 8;             // ticks per debounce interval

  // detected headset type
  typedef enum logic [1:0] {
    HSD_NONE   = 2'b00,
    HSD_STEREO = 2'b01,
    HSD_CELL   = 2'b10,
    HSD_BOTH   = 2'b11
  } hsd_type_t;

endpackage : hsd_pkg

// [hsd_gain_sat.sv]
// hsd_gain_sat: clamps a 7-bit half-dB record gain code at 59.5 dB
`timescale 1ns/1ps
module hsd_gain_sat
  import hsd_pkg::*;
(
  input  wire logic [6:0] code_in,  // code as written by software
  output logic      [6:0] code_out  // code applied to the gain stage
);
  // codes above the ceiling all give the top step, so no wrap is possible
  always_comb begin
    if (code_in > GAIN_MAX_CODE) begin
      code_out = GAIN_MAX_CODE;
    end else begin
      code_out = code_in;              // 0.5 dB per step from 0.0 dB
    end
  end
endmodule : hsd_gain_sat

// [hsd_debounce.sv]
// hsd_debounce: pin synchroniser plus tick-sampled glitch filter
`timescale 1ns/1ps
module hsd_debounce #(
  parameter int W       = 1,            // bits filtered together
  parameter int SAMPLES = 8             // stable ticks before a change
) (
  input  wire logic         clk,        // system clock
  input  wire logic         rst,        // async reset, active high
  input  wire logic         en,         // filter enabled, else output zero
  input  wire logic         bypass,     // pass synchronised input straight
  input  wire logic         tick,       // sample tick
  input  wire logic [W-1:0] pin,        // raw asynchronous input
  output logic      [W-1:0] dout        // filtered level
);
  import hsd_pkg::*;

  logic [W-1:0] s1_q, s2_q, s3_q;       // three-stage synchroniser
  logic [W-1:0] st_q;                   // agreed synchronised level
  logic [W-1:0] cand_q;                 // level being qualified
  logic [3:0]   cnt_q;                  // stable ticks seen

  // ----------------------------------------
  // synchroniser: only s2 reads s1
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      st_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        st_q <= s3_q;                   // change counts once stages agree
      end
    end
  end

  // ----------------------------------------
  // filter: any wobble restarts the count
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout   <= '0;
      cand_q <= '0;
      cnt_q  <= 4'h0;
    end else if (!en) begin
      dout   <= '0;
      cand_q <= '0;
      cnt_q  <= 4'h0;
    end else if (bypass) begin
      dout   <= st_q;                   // no debounce selected
      cand_q <= st_q;
      cnt_q  <= 4'h0;
    end else if (st_q == dout || st_q != cand_q) begin
      cand_q <= st_q;
      cnt_q  <= 4'h0;
    end else if (tick) begin
      if (cnt_q == 4'(SAMPLES - 1)) begin
        dout  <= cand_q;                // stable at every tick
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_db_hold: assert property (@(posedge clk) disable iff (rst)
    (en && !bypass && cnt_q == 4'h0 && st_q != dout && $stable(st_q))
      |=> dout == $past(dout))
    else $error("filtered level changed without a stable interval");

endmodule : hsd_debounce

// [hsd_regs.sv]
// hsd_regs: headset detect, output driver config and record gain registers
`timescale 1ns/1ps

// Summary of operation
// - detection runs only while enable bit set
// - read-only type field: none/stereo/cellular/both
// - jack debounce 16ms doubling, tick eighth
// - button debounce off, 8, 16, 32 ms
// - coupling bit selects capless or ac-coupled
// - bit flags fully-differential stereo outputs
// - bit flags pseudo-differential stereo outputs
// - sticky button flag, cleared by read
// - headset flag shows live detection
// - left stage muted by bit, reset muted
// - right stage muted by bit, reset muted
// - left gain 0.0 dB plus half-dB steps
// - codes 119 upward saturate at 59.5 dB
// - right gain own field, same encoding
module hsd_regs
  import hsd_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF        // clock cycles per 1 ms tick
) (
  input  wire logic                  clk,        // 100 MHz clock
  input  wire logic                  rst,        // async reset, active high
  input  wire logic                  reg_wr,     // register write strobe
  input  wire logic                  reg_rd,     // register read strobe
  input  wire logic [ADDR_W-1:0]     reg_addr,   // register offset
  input  wire logic [DATA_W-1:0]     reg_wdata,  // write data
  output logic      [DATA_W-1:0]     reg_rdata,  // read data
  output logic                       reg_rvalid, // read data valid pulse
  input  wire logic                  jack_pin,   // raw jack present
  input  wire logic                  stereo_pin, // raw stereo sense
  input  wire logic                  cell_pin,   // raw cellular sense
  input  wire logic                  button_pin, // raw button level
  output logic                       det_en,     // detection front end on
  output hsd_type_t                  hs_type,    // debounced headset type
  output logic                       hs_present, // debounced headset present
  output logic                       btn_flag,   // sticky button press
  output logic                       drv_ac,     // ac-coupled outputs
  output logic                       drv_fdiff,  // fully-differential mode
  output logic                       drv_pdiff,  // pseudo-differential mode
  output logic                       mute_l,     // left record stage muted
  output logic                       mute_r,     // right record stage muted
  output logic      [6:0]            gain_l,     // left applied gain code
  output logic      [6:0]            gain_r      // right applied gain code
);
  import hsd_pkg::*;

  localparam int MSW = $clog2(MS_CYCLES + 1);    // ms counter width

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic       det_en_q;                   // detection enable
  logic [2:0] jdb_q;                      // jack debounce code
  logic [1:0] bdb_q;                      // button debounce code
  logic       ac_q;                       // coupling bit
  logic       fdiff_q;                    // fully-differential bit
  logic       pdiff_q;                    // pseudo-differential bit
  logic       flag_q;                     // sticky button flag
  logic [7:0] gl_q;                       // left gain register
  logic [7:0] gr_q;                       // right gain register
  logic [6:0] gl_sat, gr_sat;             // clamped gain codes
  logic [6:0] gl_out_q, gr_out_q;         // applied gain codes
  logic [7:0] rdata_q;                    // read data
  logic       rvalid_q;                   // read answer pulse
  logic       btn_prev_q;                 // last filtered button level

  logic [MSW-1:0] ms_cnt_q;               // cycles within one ms
  logic           ms_tick_q;              // one-cycle 1 ms tick
  logic [6:0]     ms_idx_q;               // free ms index for slower ticks
  logic [6:0]     jack_mask;              // low index bits per jack code
  logic [6:0]     btn_mask;               // low index bits per button code
  logic           jack_tick;              // jack sample tick
  logic           btn_tick;               // button sample tick
  logic [2:0]     jack_db;                // {cell, stereo, present}
  logic [0:0]     btn_db;                 // filtered button level
  logic           wr_det, wr_stat;        // decoded writes
  logic           wr_gl, wr_gr;
  logic           rd_stat;                // read of the status register
  logic           btn_rise;               // debounced press

  assign wr_det  = reg_wr && reg_addr == OFS_DET_CTRL;
  assign wr_stat = reg_wr && reg_addr == OFS_STAT_CFG;
  assign wr_gl   = reg_wr && reg_addr == OFS_GAIN_L;
  assign wr_gr   = reg_wr && reg_addr == OFS_GAIN_R;
  assign rd_stat = reg_rd && reg_addr == OFS_STAT_CFG;

  // ----------------------------------------
  // sample tick generation
  // ----------------------------------------
  // one shared ms base keeps both filters phase-aligned and cheap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_cnt_q  <= '0;
      ms_tick_q <= 1'b0;
      ms_idx_q  <= 7'h00;
    end else begin
      ms_tick_q <= 1'b0;
      if (ms_cnt_q == MSW'(MS_CYCLES - 1)) begin
        ms_cnt_q  <= '0;
        ms_tick_q <= 1'b1;
        ms_idx_q  <= ms_idx_q + 7'h01;
      end else begin
        ms_cnt_q <= ms_cnt_q + MSW'(1);
      end
    end
  end

  // jack tick is 2 ms doubled per code step; button 1 ms at code 01, doubled per step
  always_comb begin
    jack_mask = (7'h02 << jdb_q) - 7'h01;
    btn_mask  = ((7'h01 << bdb_q) >> 1) - 7'h01;
  end

  // a tick lands on every ms whose low index bits are zero
  assign jack_tick = ms_tick_q && (ms_idx_q & jack_mask) == 7'h00;
  assign btn_tick  = ms_tick_q && (ms_idx_q & btn_mask) == 7'h00;

  // ----------------------------------------
  // jack and button filters
  // ----------------------------------------
  // type and present travel together, so a half-seated plug never splits them
  hsd_debounce #(
    .W       (3),
    .SAMPLES (DB_SAMPLES)
  ) u_jack_db (
    .clk    (clk),
    .rst    (rst),
    .en     (det_en_q),
    .bypass (1'b0),
    .tick   (jack_tick),
    .pin    ({cell_pin, stereo_pin, jack_pin}),
    .dout   (jack_db)
  );

  // button filter only runs while detection is on
  hsd_debounce #(
    .W       (1),
    .SAMPLES (DB_SAMPLES)
  ) u_btn_db (
    .clk    (clk),
    .rst    (rst),
    .en     (det_en_q),
    .bypass (bdb_q == 2'b00),
    .tick   (btn_tick),
    .pin    (button_pin),
    .dout   (btn_db)
  );

  assign btn_rise = btn_db[0] && !btn_prev_q;

  // ----------------------------------------
  // detection control register
  // ----------------------------------------
  // reserved jack codes are the host's concern; they only slow the tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_en_q <= RST_DET_CTRL[DET_EN_BIT];
      jdb_q    <= RST_DET_CTRL[JDB_LSB +: 3];
      bdb_q    <= RST_DET_CTRL[BDB_LSB +: 2];
    end else if (wr_det) begin
      det_en_q <= reg_wdata[DET_EN_BIT];
      jdb_q    <= reg_wdata[JDB_LSB +: 3];
      bdb_q    <= reg_wdata[BDB_LSB +: 2];
    end
  end

  // ----------------------------------------
  // output driver configuration
  // ----------------------------------------
  // both differential bits set is not blocked; the host must avoid it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ac_q    <= RST_STAT_CFG[COUPLE_BIT];
      fdiff_q <= RST_STAT_CFG[FULLDIFF_BIT];
      pdiff_q <= RST_STAT_CFG[PSEUDO_BIT];
    end else if (wr_stat) begin
      ac_q    <= reg_wdata[COUPLE_BIT];
      fdiff_q <= reg_wdata[FULLDIFF_BIT];
      pdiff_q <= reg_wdata[PSEUDO_BIT];
    end
  end

  // ----------------------------------------
  // sticky button flag
  // ----------------------------------------
  // a press in the same cycle as the clearing read survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q     <= RST_STAT_CFG[BTN_FLAG_BIT];
      btn_prev_q <= 1'b0;
    end else begin
      btn_prev_q <= btn_db[0];
      if (btn_rise) begin
        flag_q <= 1'b1;
      end else if (rd_stat) begin
        flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // record gain registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gl_q <= RST_GAIN;
    end else if (wr_gl) begin
      gl_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gr_q <= RST_GAIN;
    end else if (wr_gr) begin
      gr_q <= reg_wdata;
    end
  end

  // stored code reads back as written; only the applied code clamps
  hsd_gain_sat u_sat_l (
    .code_in  (gl_q[GAIN_LSB +: 7]),
    .code_out (gl_sat)
  );

  hsd_gain_sat u_sat_r (
    .code_in  (gr_q[GAIN_LSB +: 7]),
    .code_out (gr_sat)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gl_out_q <= RST_GAIN[GAIN_LSB +: 7];
      gr_out_q <= RST_GAIN[GAIN_LSB +: 7];
    end else begin
      gl_out_q <= gl_sat;
      gr_out_q <= gr_sat;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // unmapped offsets answer zero; reserved bits read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          OFS_DET_CTRL: rdata_q <= {det_en_q, jack_db[2:1], jdb_q, bdb_q};
          OFS_STAT_CFG: rdata_q <= {ac_q, fdiff_q, flag_q, jack_db[0],
                                    pdiff_q, 3'h0};
          OFS_GAIN_L:   rdata_q <= gl_q;
          OFS_GAIN_R:   rdata_q <= gr_q;
          default:      rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign det_en     = det_en_q;
  assign hs_type    = hsd_type_t'(jack_db[2:1]);
  assign hs_present = jack_db[0];
  assign btn_flag   = flag_q;
  assign drv_ac     = ac_q;
  assign drv_fdiff  = fdiff_q;
  assign drv_pdiff  = pdiff_q;
  assign mute_l     = gl_q[MUTE_BIT];
  assign mute_r     = gr_q[MUTE_BIT];
  assign gain_l     = gl_out_q;
  assign gain_r     = gr_out_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_det_off_quiet: assert property (
    !det_en_q ##1 !det_en_q |-> hs_present == 1'b0 && hs_type == HSD_NONE)
    else $error("detection reported while disabled");

  chk_type_read: assert property (
    reg_rd && reg_addr == OFS_DET_CTRL |=> reg_rvalid
      && reg_rdata[TYPE_LSB +: 2] == $past(jack_db[2:1]))
    else $error("type field read mismatch");

  // ms ticks seen since the last jack tick; a write restarts it so a code
  // change in mid-interval never trips the spacing check below
  logic [6:0] jt_gap_q;                   // ms ticks since last jack tick
  logic       jt_seen_q;                  // a jack tick passed since last write

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      jt_gap_q  <= 7'h00;
      jt_seen_q <= 1'b0;
    end else if (wr_det) begin
      jt_gap_q  <= 7'h00;                 // new code, new phase
      jt_seen_q <= 1'b0;
    end else if (jack_tick) begin
      jt_gap_q  <= 7'h00;
      jt_seen_q <= 1'b1;
    end else if (ms_tick_q) begin
      jt_gap_q  <= jt_gap_q + 7'h01;      // one more ms without a jack tick
    end
  end

  chk_jack_tick: assert property (
    jack_tick && jt_seen_q && jdb_q <= 3'h5
      |-> ms_tick_q && jt_gap_q == (7'h02 << jdb_q) - 7'h01)
    else $error("jack tick spacing not 2 ms doubled per code");

  chk_btn_bypass: assert property (
    det_en_q && bdb_q == 2'b00 && $stable(bdb_q) && $stable(det_en_q)
      |=> btn_db[0] == $past(u_btn_db.st_q))
    else $error("button not passed straight with no debounce");

  chk_drv_cfg: assert property (
    wr_stat |=> drv_ac == $past(reg_wdata[COUPLE_BIT])
      && drv_fdiff == $past(reg_wdata[FULLDIFF_BIT])
      && drv_pdiff == $past(reg_wdata[PSEUDO_BIT]))
    else $error("driver config not taken from write");

  chk_btn_set: assert property (
    btn_rise |=> btn_flag ##1 (btn_flag || $past(rd_stat)))
    else $error("button press lost");

  chk_btn_clear: assert property (
    rd_stat && !btn_rise |=> !btn_flag)
    else $error("button flag not cleared by read");

  chk_hs_read: assert property (
    rd_stat |=> reg_rdata[HS_FLAG_BIT] == $past(hs_present)
      && reg_rdata[2:0] == 3'h0)
    else $error("headset flag read mismatch");

  chk_mute_write: assert property (
    wr_gl |=> mute_l == $past(reg_wdata[MUTE_BIT]))
    else $error("left mute not taken from write");

  chk_mute_r_write: assert property (
    wr_gr |=> mute_r == $past(reg_wdata[MUTE_BIT]))
    else $error("right mute not taken from write");

  chk_gain_track: assert property (
    wr_gl && reg_wdata[6:0] <= GAIN_MAX_CODE |=> ##1 gain_l == $past(reg_wdata[6:0], 2))
    else $error("left gain not applied");

  chk_gain_ceiling: assert property (
    wr_gr && reg_wdata[6:0] > GAIN_MAX_CODE |=> ##1 gain_r == GAIN_MAX_CODE)
    else $error("gain did not saturate");

  chk_gain_indep: assert property (
    wr_gr && !wr_gl |=> ##1 gain_l == $past(gain_l))
    else $error("right write moved left gain");

  cov_btn_flag: cover property (btn_rise ##1 btn_flag);
  cov_plug_in: cover property ($rose(hs_present));
  cov_gain_sat: cover property (gain_l == GAIN_MAX_CODE && gl_q[6:0] > GAIN_MAX_CODE);

endmodule : hsd_regs

// [hsd_jack_model.sv]
// hsd_jack_model: headset plug and button as seen at the codec pins
`timescale 1ns/1ps
module hsd_jack_model (
  input  wire logic       clk,        // bench clock
  input  wire logic       plug,       // headset inserted
  input  wire logic [1:0] kind,       // {cellular, stereo} contacts
  input  wire logic       press,      // button held
  output logic            jack_pin,   // jack contact
  output logic            stereo_pin, // stereo sense
  output logic            cell_pin,   // cellular sense
  output logic            button_pin  // button contact
);
  logic [1:0] last_q   = 2'h0;        // previous plug/press request
  logic [2:0] bounce_q = 3'h0;        // chatter cycles still to run
  // real contacts chatter after every change, so the filter must see it
  always @(posedge clk) begin
    last_q <= {plug, press};
    if ({plug, press} != last_q) bounce_q <= 3'h5;
    else if (bounce_q != 3'h0) bounce_q <= bounce_q - 3'h1;
  end
  assign jack_pin   = (bounce_q != 3'h0) ? bounce_q[0] : plug;  // chatters
  assign button_pin = (bounce_q != 3'h0) ? bounce_q[0] : press; // chatters
  assign stereo_pin = plug & kind[0]; // sense lines follow the plug
  assign cell_pin   = plug & kind[1]; // sense lines follow the plug
endmodule : hsd_jack_model

// [hsd_regs_tb_top.sv]
// hsd_regs_tb_top: directed checks of the headset and record gain registers
`timescale 1ns/1ps
module hsd_regs_tb_top;
  import hsd_pkg::*;
  localparam int MS    = 4;     // short 1 ms base keeps debounce runs brief
  localparam int LIMIT = 60000; // cycle ceiling for the whole run
  logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd;
  logic       plug = 1'b0, press = 1'b0;
  logic [1:0] kind = 2'h0;
  int         n_mismatch = 0, n_compared = 0, cycles = 0;
  logic [7:0] reg_rdata;
  logic       reg_rvalid, jack_pin, stereo_pin, cell_pin, button_pin;
  logic       det_en, hs_present, btn_flag, drv_ac, drv_fdiff, drv_pdiff;
  logic       mute_l, mute_r;
  logic [6:0] gain_l, gain_r;
  hsd_type_t  hs_type;
  always #5 clk = ~clk; // 100 MHz
  hsd_jack_model hsd_jack_model_i (.clk, .plug, .kind, .press, .jack_pin,
    .stereo_pin, .cell_pin, .button_pin);
  hsd_regs #(.MS_CYCLES(MS)) hsd_regs_i (.clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .jack_pin, .stereo_pin,
    .cell_pin, .button_pin, .det_en, .hs_type, .hs_present, .btn_flag,
    .drv_ac, .drv_fdiff, .drv_pdiff, .mute_l, .mute_r, .gain_l, .gain_r);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
    rd = reg_rdata;
  endtask : rdr
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset(); // reset values, unmapped offset reads zero
    logic [7:0] ofs[5] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11};
    logic [7:0] exp[5] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h00};
    foreach (ofs[i]) begin
      rdr(ofs[i]);
      chk("reset value", rd, exp[i]);
    end
    chk("reset mutes", {6'h0, mute_l, mute_r}, 8'h03);
  endtask : t_reset
  task automatic t_gain(); // edge codes, saturation, channel independence
    logic [7:0] c[6] = '{8'h00, 8'h01, 8'h76, 8'h77, 8'h78, 8'h7F};
    foreach (c[i]) begin
      wr(OFS_GAIN_L, c[i]);
      wr(OFS_GAIN_R, 8'h80 | (8'h7F - c[i]));
      @(posedge clk);
      #1;
      chk("gain_l", {1'b0, gain_l}, (c[i] > 8'h77) ? 8'h77 : c[i]);
      chk("gain_r", {1'b0, gain_r}, (c[i] < 8'h08) ? 8'h77 : 8'h7F - c[i]);
      chk("mutes", {6'h0, mute_l, mute_r}, 8'h01);
      rdr(OFS_GAIN_L);
      chk("gain_l readback", rd, c[i]);
      rdr(OFS_GAIN_R);
      chk("gain_r readback", rd, 8'h80 | (8'h7F - c[i]));
    end
  endtask : t_gain
  task automatic t_cfg(); // driver modes; host keeps reserved bits zero
    logic [7:0] v[4] = '{8'h80, 8'h40, 8'h08, 8'h00}; // never D6+D3
    foreach (v[i]) begin
      wr(OFS_STAT_CFG, v[i]);
      chk("drivers", {5'h0, drv_ac, drv_fdiff, drv_pdiff},
          {5'h0, v[i][7], v[i][6], v[i][3]});
      rdr(OFS_STAT_CFG);
      chk("cfg readback", rd, v[i]);
    end
    wr(OFS_DET_CTRL, 8'h60); // read-only type bits, code 000
    rdr(OFS_DET_CTRL);
    chk("type not writable", rd, 8'h00);
  endtask : t_cfg
  task automatic t_detect(input logic [2:0] jc, input logic [1:0] k);
    int t = (2 * MS) << jc; // sample tick in cycles
    int n = 0;
    wr(OFS_DET_CTRL, 8'h00);
    plug <= 1'b1;
    kind <= k;
    repeat (40) @(negedge clk);
    chk("off type", {6'h0, hs_type}, 8'h00);
    chk("off present", {7'h0, hs_present}, 8'h00);
    chk("det_en off", {7'h0, det_en}, 8'h00);
    wr(OFS_DET_CTRL, {1'b1, 2'b00, jc, 2'b00}); // jack code below 110
    chk("det_en on", {7'h0, det_en}, 8'h01);
    while (!(hs_present === 1'b1 && hs_type === hsd_type_t'(k)) && n < 9 * t) begin
      @(negedge clk);
      n++;
    end
    chk("jack delay", 8'(n >= 7 * t && n <= 8 * t + 20), 8'h01);
    rdr(OFS_DET_CTRL);
    chk("type field", rd, {1'b1, k, jc, 2'b00});
    rdr(OFS_STAT_CFG);
    chk("hs flag", {7'h0, rd[HS_FLAG_BIT]}, 8'h01);
  endtask : t_detect
  task automatic t_button(input logic [1:0] bc);
    int t = (bc == 2'b00) ? 0 : MS << (bc - 2'b01); // sample tick in cycles
    int n = 0;
    wr(OFS_DET_CTRL, {6'h20, bc});
    rdr(OFS_STAT_CFG);
    press <= 1'b1;
    while (btn_flag !== 1'b1 && n < 9 * t + 30) begin
      @(negedge clk);
      n++;
    end
    chk("button delay", 8'(n >= 7 * t && n <= 8 * t + 20), 8'h01);
    press <= 1'b0;
    repeat (9 * t + 30) @(negedge clk); // filter must settle on the release
    rdr(OFS_STAT_CFG);
    chk("flag held", {7'h0, rd[BTN_FLAG_BIT]}, 8'h01);
    rdr(OFS_STAT_CFG);
    chk("flag cleared", {7'h0, rd[BTN_FLAG_BIT]}, 8'h00);
  endtask : t_button
  always @(posedge clk) begin // hang guard
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_gain();
    t_cfg();
    for (int k = 0; k < 4; k++) t_detect(3'h0, 2'(k + 1));
    t_detect(3'h5, 2'h1);
    for (int b = 0; b < 4; b++) t_button(2'(b));
    end_of_test();
  end
endmodule : hsd_regs_tb_top
